// ---- design/tap_defs.svh ----
// register map, field positions, reset values and count constants of the timer channel
`ifndef TAP_DEFS_SVH
`define TAP_DEFS_SVH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define TAP_OFF_CTRL 8'h00
`define TAP_OFF_TIMER 8'h04
`define TAP_OFF_STATUS 8'h08
`define TAP_OFF_SWTRIG 8'h0C
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define TAP_CTRL_START 0
`define TAP_CTRL_MODE 2:1
`define TAP_CTRL_PWM8 3
`define TAP_CTRL_TSEL 5:4
`define TAP_CTRL_OSEL 7:6
`define TAP_CTRL_CSEL 9:8
`define TAP_CTRL_UP 10
`define TAP_CTRL_FREE 11
`define TAP_STAT_FLAG 0
`define TAP_STAT_OUT 1
`define TAP_STAT_BUSY 2
// ------------------------------------------------------------
// reset values and counts
// ------------------------------------------------------------
`define TAP_RST_RLD 16'h0000
`define TAP_PWM16_SPAN 16'hFFFF
`define TAP_PWM8_SPAN 8'hFF
`define TAP_DIV8_MASK 5'h07
`define TAP_DIV32_MASK 5'h1F
`define TAP_RESP_OKAY 2'h0
`define TAP_RESP_SLVERR 2'h2
`endif

// ---- design/tap_pkg.sv ----
// types of the timer channel: modes, selects, states and the state record
package tap_pkg;
  typedef enum logic [1:0] {
    MD_TIMER = 2'h0,
    MD_EVENT = 2'h1,
    MD_ONESHOT = 2'h2,
    MD_PWM = 2'h3
  } tap_mode_t;
  typedef enum logic [1:0] {
    TS_SOFT = 2'h0,
    TS_FALL = 2'h1,
    TS_RISE = 2'h2,
    TS_OVF = 2'h3
  } tap_trig_t;
  typedef enum logic [1:0] {
    CS_DIV1 = 2'h0,
    CS_DIV8 = 2'h1,
    CS_DIV32 = 2'h2,
    CS_SUB32 = 2'h3
  } tap_clk_t;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ARMED = 6'h02,
    ST_HIGH = 6'h04,
    ST_LOW = 6'h08,
    ST_LEAD = 6'h10,
    ST_RUN = 6'h20
  } tap_state_t;
  typedef struct packed {
    tap_state_t st;
    logic start;
    tap_mode_t mode;
    logic pwm8;
    tap_trig_t tsel;
    logic [1:0] osel;
    tap_clk_t csel;
    logic up;
    logic free;
    logic [15:0] cnt;
    logic [15:0] rld;
    logic out;
    logic flag;
    logic ovf;
    logic [1:0] rtg;
    logic rl_inst;
    logic [15:0] rl_val;
    logic sw_trg;
    logic [4:0] pre;
    logic [4:0] sub_cnt;
    logic [2:0] sub_s;
    logic [2:0] trg_s;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } tap_regs_t;
endpackage : tap_pkg

// ---- design/tap_timer_chan.sv ----
// one timer channel, down-counting except event mode with up set, with PWM, one-shot, timer and event modes behind AXI4-Lite
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "tap_defs.svh"

// Overview of operation
// RL1 - 16-bit PWM: selected trigger with start set begins counting and drives output high.
// RL2 - when the high time ends the output falls and the request flag sets.
// RL3 - both PWM variants reload at each cycle end and keep running unaided.
// RL4 - clearing start in PWM freezes the counter, stops it and forces output low.
// RL5 - 16-bit PWM period is 65535 ticks, high time n ticks.
// RL6 - 16-bit PWM with value zero never starts; output stays low.
// RL7 - 8-bit PWM period (m+1)*255 ticks, high time n*(m+1) ticks.
// RL8 - 8-bit PWM with upper byte zero is inactive; output stays low.
// RL9 - 8-bit PWM first holds low for one high time, then pulses.
// RL10 - reset clears the start flag.
// RL11 - software loads the value while stopped, then sets start.
// RL12 - timer mode read returns live count, or all ones at reload instant.
// RL13 - value written while stopped reads back until counting resumes.
// RL14 - event mode reload instant reads all ones after underflow, zeros after overflow.
// RL15 - software rewrites the value after stopping a free-running event count.
// RL16 - one-shot stop mid-count reloads, drives output low and sets the flag.
// RL17 - one-shot output moves on count-source ticks, lagging a trigger up to one.
// RL18 - entering one-shot from reset, timer or event mode sets the flag.
// RL19 - one-shot retrigger: one more down count, then reload and keep counting.
// RL20 - retriggers come more than one count-source tick after the last trigger.
// RL21 - count source is one of three main-clock divisions or divided sub clock.
// RL22 - start on input falling edge, rising edge, or a neighbour's overflow.
// RL23 - PWM stop while high sets the flag; while low changes nothing.
// RL24 - entering PWM from reset, timer or event mode sets the flag.
// RL25 - 8-bit PWM: lower byte is prescaler m, upper byte high count n.
module tap_timer_chan (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic TRIG_IN,
  input wire logic SUB_CLK,
  input wire logic UNIT2_OVF,
  input wire logic LOWER_OVF,
  input wire logic UPPER_OVF,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic PULSE_OUT,
  output logic OVF_OUT,
  output logic IRQ_FLAG
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [3:0] reg_sel(input logic [7:0] a);
    reg_sel = {a == `TAP_OFF_SWTRIG, a == `TAP_OFF_STATUS, a == `TAP_OFF_TIMER, a == `TAP_OFF_CTRL};
  endfunction : reg_sel

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction : merge

  // one prescaled step of the 8-bit modulator: low byte counts m+1 ticks per upper-byte step
  function automatic logic [15:0] step8(input logic [15:0] c, input logic [7:0] m);
    if (c[7:0] != 8'h00) begin
      step8 = {c[15:8], c[7:0] - 8'h01};
    end else begin
      step8 = {c[15:8] - 8'h01, m}; // RL25
    end
  endfunction : step8

  tap_pkg::tap_regs_t s_r;
  tap_pkg::tap_regs_t s_nxt;
  logic trg_rise;
  logic trg_fall;
  logic sub_edge;
  logic ovf_in;
  logic tick;
  logic trig;
  logic run_ev;
  logic pwm_on;
  logic no_low;
  logic end16;
  logic end8;
  logic endp;
  logic wr_go;
  logic setf;
  logic clrf;
  logic [3:0] wsel;
  logic [3:0] rsel;
  logic [31:0] wv;
  logic [15:0] cnt_step;
  logic [31:0] ctrl_rd;

  // ------------------------------------------------------------
  // count source and trigger selection
  // ------------------------------------------------------------
  // pins are read only after the second synchroniser stage
  assign trg_rise = s_r.trg_s[1] & ~s_r.trg_s[2];
  assign trg_fall = ~s_r.trg_s[1] & s_r.trg_s[2];
  assign sub_edge = s_r.sub_s[1] & ~s_r.sub_s[2];
  assign tick = (s_r.csel == tap_pkg::CS_DIV1) |
                ((s_r.csel == tap_pkg::CS_DIV8) & ((s_r.pre & `TAP_DIV8_MASK) == `TAP_DIV8_MASK)) |
                ((s_r.csel == tap_pkg::CS_DIV32) & (s_r.pre == `TAP_DIV32_MASK)) |
                ((s_r.csel == tap_pkg::CS_SUB32) & sub_edge & (s_r.sub_cnt == `TAP_DIV32_MASK)); // RL21
  assign ovf_in = (s_r.osel == 2'h0) ? UNIT2_OVF : (s_r.osel == 2'h1) ? LOWER_OVF : UPPER_OVF;
  assign trig = (s_r.tsel == tap_pkg::TS_FALL) ? trg_fall :
                (s_r.tsel == tap_pkg::TS_RISE) ? trg_rise :
                (s_r.tsel == tap_pkg::TS_OVF) ? ovf_in : s_r.sw_trg; // RL22
  assign run_ev = (s_r.mode == tap_pkg::MD_TIMER) ? tick : trig;
  assign pwm_on = (s_r.mode == tap_pkg::MD_PWM) &
                  (s_r.pwm8 ? (s_r.rld[15:8] != 8'h00) : (s_r.rld != 16'h0000)); // RL6 RL8
  assign no_low = s_r.pwm8 ? (s_r.rld[15:8] == `TAP_PWM8_SPAN) : (s_r.rld == `TAP_PWM16_SPAN);
  assign end16 = s_r.cnt == 16'h0001;
  assign end8 = (s_r.cnt[7:0] == 8'h00) & (s_r.cnt[15:8] == 8'h01);
  assign endp = s_r.pwm8 ? end8 : end16;
  assign cnt_step = s_r.pwm8 ? step8(s_r.cnt, s_r.rld[7:0]) : s_r.cnt - 16'h0001;
  assign wr_go = s_r.aw_got & s_r.w_got;
  assign ctrl_rd = {20'h00000, s_r.free, s_r.up, s_r.csel, s_r.osel, s_r.tsel, s_r.pwm8, s_r.mode, s_r.start};

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    setf = 1'b0;
    clrf = 1'b0;
    wv = 32'h00000000;
    wsel = reg_sel(s_r.waddr);
    rsel = reg_sel(S_AXI_ARADDR[7:0]);
    s_nxt.trg_s = {s_r.trg_s[1:0], TRIG_IN};
    s_nxt.sub_s = {s_r.sub_s[1:0], SUB_CLK};
    s_nxt.pre = s_r.pre + 5'h01;
    if (sub_edge) begin
      s_nxt.sub_cnt = s_r.sub_cnt + 5'h01;
    end
    s_nxt.ovf = 1'b0;
    s_nxt.rl_inst = 1'b0;
    s_nxt.sw_trg = 1'b0;
    unique case (s_r.st)
      tap_pkg::ST_IDLE: begin
        if (s_r.start) begin
          if (s_r.mode == tap_pkg::MD_TIMER || s_r.mode == tap_pkg::MD_EVENT) begin
            s_nxt.st = tap_pkg::ST_RUN;
          end else if (trig && (s_r.mode == tap_pkg::MD_ONESHOT || pwm_on)) begin
            s_nxt.st = tap_pkg::ST_ARMED; // RL1
          end
        end
      end
      tap_pkg::ST_ARMED: begin
        // output waits for the next count-source tick, so it lags the trigger by up to one tick
        if (tick) begin
          s_nxt.cnt = s_r.rld; // RL17
          if (s_r.mode == tap_pkg::MD_PWM && s_r.pwm8) begin
            s_nxt.st = tap_pkg::ST_LEAD; // RL9
          end else begin
            s_nxt.st = tap_pkg::ST_HIGH;
            s_nxt.out = 1'b1; // RL1
          end
        end
      end
      tap_pkg::ST_HIGH: begin
        if (s_r.mode == tap_pkg::MD_ONESHOT) begin
          if (trig && s_r.rtg == 2'h0) begin
            s_nxt.rtg = 2'h1; // RL19
          end
          if (tick) begin
            if (s_r.rtg == 2'h1) begin
              s_nxt.cnt = s_r.cnt - 16'h0001; // RL19
              s_nxt.rtg = 2'h2;
            end else if (s_r.rtg == 2'h2) begin
              s_nxt.cnt = s_r.rld; // RL19
              s_nxt.rtg = 2'h0;
            end else if (s_r.cnt[15:1] == 15'h0000) begin
              s_nxt.out = 1'b0;
              s_nxt.cnt = s_r.rld;
              s_nxt.st = tap_pkg::ST_IDLE;
              setf = 1'b1;
            end else begin
              s_nxt.cnt = s_r.cnt - 16'h0001;
            end
          end
        end else if (tick) begin
          if (endp) begin
            // full-scale value leaves no low time: keep high, no falling edge, no flag
            if (no_low) begin
              s_nxt.cnt = s_r.rld;
            end else begin
              s_nxt.out = 1'b0; // RL2
              setf = 1'b1; // RL2
              s_nxt.st = tap_pkg::ST_LOW;
              if (s_r.pwm8) begin
                s_nxt.cnt = {`TAP_PWM8_SPAN - s_r.rld[15:8], s_r.rld[7:0]}; // RL7
              end else begin
                s_nxt.cnt = `TAP_PWM16_SPAN - s_r.rld; // RL5
              end
            end
          end else begin
            s_nxt.cnt = cnt_step;
          end
        end
      end
      tap_pkg::ST_LOW, tap_pkg::ST_LEAD: begin
        if (tick) begin
          if (endp) begin
            if (pwm_on) begin
              s_nxt.cnt = s_r.rld; // RL3
              s_nxt.out = 1'b1;
              s_nxt.st = tap_pkg::ST_HIGH;
            end else begin
              s_nxt.st = tap_pkg::ST_IDLE; // RL6 RL8
            end
          end else begin
            s_nxt.cnt = cnt_step;
          end
        end
      end
      tap_pkg::ST_RUN: begin
        if (run_ev) begin
          if (s_r.mode == tap_pkg::MD_EVENT && s_r.up) begin
            if (s_r.cnt == 16'hFFFF) begin
              s_nxt.cnt = s_r.free ? 16'h0000 : s_r.rld;
              s_nxt.rl_inst = 1'b1;
              s_nxt.rl_val = 16'h0000; // RL14
              s_nxt.ovf = 1'b1;
              setf = 1'b1;
            end else begin
              s_nxt.cnt = s_r.cnt + 16'h0001;
            end
          end else if (s_r.cnt == 16'h0000) begin
            s_nxt.cnt = (s_r.free && s_r.mode == tap_pkg::MD_EVENT) ? 16'hFFFF : s_r.rld;
            s_nxt.rl_inst = 1'b1;
            s_nxt.rl_val = 16'hFFFF; // RL12 RL14
            s_nxt.ovf = 1'b1;
            setf = 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt - 16'h0001;
          end
        end
      end
      default: begin
        s_nxt.st = tap_pkg::ST_IDLE;
      end
    endcase
    // ------------------------------------------------------------
    // stop
    // ------------------------------------------------------------
    if (!s_r.start && s_r.st != tap_pkg::ST_IDLE) begin
      s_nxt.st = tap_pkg::ST_IDLE;
      s_nxt.rtg = 2'h0;
      s_nxt.out = 1'b0; // RL4
      if (s_r.mode == tap_pkg::MD_ONESHOT) begin
        s_nxt.cnt = s_r.rld; // RL16
        setf = setf | (s_r.st == tap_pkg::ST_HIGH); // RL16
      end else begin
        s_nxt.cnt = s_r.cnt; // RL4
        setf = setf | s_r.out; // RL23
      end
    end
    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    if (S_AXI_AWVALID && s_r.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.waddr = S_AXI_AWADDR[7:0];
    end
    if (S_AXI_WVALID && s_r.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = S_AXI_WDATA;
      s_nxt.wstrb = S_AXI_WSTRB;
    end
    if (s_r.bvalid && S_AXI_BREADY) begin
      s_nxt.bvalid = 1'b0;
    end
    if (wr_go) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = (wsel == 4'h0) ? `TAP_RESP_SLVERR : `TAP_RESP_OKAY;
      if (wsel[0]) begin
        wv = merge(ctrl_rd, s_r.wdata, s_r.wstrb);
        s_nxt.start = wv[`TAP_CTRL_START];
        s_nxt.mode = tap_pkg::tap_mode_t'(wv[`TAP_CTRL_MODE]);
        s_nxt.pwm8 = wv[`TAP_CTRL_PWM8];
        s_nxt.tsel = tap_pkg::tap_trig_t'(wv[`TAP_CTRL_TSEL]);
        s_nxt.osel = wv[`TAP_CTRL_OSEL];
        s_nxt.csel = tap_pkg::tap_clk_t'(wv[`TAP_CTRL_CSEL]);
        s_nxt.up = wv[`TAP_CTRL_UP];
        s_nxt.free = wv[`TAP_CTRL_FREE];
        if (!s_r.mode[1] && wv[2]) begin
          setf = 1'b1; // RL18 RL24
        end
      end
      if (wsel[1]) begin
        wv = merge({16'h0000, s_r.rld}, s_r.wdata, s_r.wstrb);
        s_nxt.rld = wv[15:0];
        // a running count only takes the new value at its next reload
        if (s_r.st == tap_pkg::ST_IDLE) begin
          s_nxt.cnt = wv[15:0]; // RL13
        end
      end
      if (wsel[2] && s_r.wstrb[0] && s_r.wdata[`TAP_STAT_FLAG]) begin
        clrf = 1'b1;
      end
      if (wsel[3] && s_r.wstrb[0] && s_r.wdata[0]) begin
        s_nxt.sw_trg = 1'b1;
      end
    end
    if (S_AXI_ARVALID && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = (rsel == 4'h0) ? `TAP_RESP_SLVERR : `TAP_RESP_OKAY;
      s_nxt.rdata = 32'h00000000;
      if (rsel[0]) begin
        s_nxt.rdata = ctrl_rd;
      end
      if (rsel[1]) begin
        s_nxt.rdata = {16'h0000, s_r.rl_inst ? s_r.rl_val : s_r.cnt}; // RL12 RL13 RL14
      end
      if (rsel[2]) begin
        s_nxt.rdata = {29'h00000000, s_r.st != tap_pkg::ST_IDLE, s_r.out, s_r.flag};
      end
    end else if (s_r.rvalid && S_AXI_RREADY) begin
      s_nxt.rvalid = 1'b0;
    end
    s_nxt.awready = ~s_nxt.aw_got & ~s_nxt.bvalid;
    s_nxt.wready = ~s_nxt.w_got & ~s_nxt.bvalid;
    s_nxt.arready = ~s_nxt.rvalid;
    // a new event outweighs a clear in the same cycle
    s_nxt.flag = (s_r.flag & ~clrf) | setf;
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      s_r <= '0;
      s_r.st <= tap_pkg::ST_IDLE;
      s_r.rld <= `TAP_RST_RLD;
      s_r.start <= 1'b0; // RL10
    end else begin
      s_r <= s_nxt;
    end
  end

  assign S_AXI_AWREADY = s_r.awready;
  assign S_AXI_WREADY = s_r.wready;
  assign S_AXI_BVALID = s_r.bvalid;
  assign S_AXI_BRESP = s_r.bresp;
  assign S_AXI_ARREADY = s_r.arready;
  assign S_AXI_RVALID = s_r.rvalid;
  assign S_AXI_RRESP = s_r.rresp;
  assign S_AXI_RDATA = s_r.rdata;
  assign PULSE_OUT = s_r.out;
  assign OVF_OUT = s_r.ovf;
  assign IRQ_FLAG = s_r.flag;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_pwm_rise_out: assert property (@(posedge MCLK) disable iff (!RST_N) // RL1
    (s_r.st == tap_pkg::ST_ARMED && tick && s_r.start && s_r.mode == tap_pkg::MD_PWM && !s_r.pwm8)
    |=> PULSE_OUT && s_r.st == tap_pkg::ST_HIGH) else $error("pwm trigger did not raise output");
  chk_fall_sets_flag: assert property (@(posedge MCLK) disable iff (!RST_N) // RL2
    ($fell(PULSE_OUT) && s_r.mode == tap_pkg::MD_PWM) |-> IRQ_FLAG) else $error("pwm fall without flag");
  chk_stop_freeze: assert property (@(posedge MCLK) disable iff (!RST_N) // RL4
    (s_r.mode == tap_pkg::MD_PWM && !s_r.start && s_r.st != tap_pkg::ST_IDLE)
    |=> !PULSE_OUT && s_r.cnt == $past(s_r.cnt) && s_r.st == tap_pkg::ST_IDLE) else $error("pwm stop wrong");
  chk_zero_stays_low: assert property (@(posedge MCLK) disable iff (!RST_N) // RL6
    (s_r.mode == tap_pkg::MD_PWM && !s_r.pwm8 && s_r.rld == 16'h0000 && s_r.st == tap_pkg::ST_IDLE)
    |=> !PULSE_OUT) else $error("zero value produced a pulse");
  chk_lead_low: assert property (@(posedge MCLK) disable iff (!RST_N) // RL9
    (s_r.st == tap_pkg::ST_ARMED && tick && s_r.start && s_r.mode == tap_pkg::MD_PWM && s_r.pwm8)
    |=> s_r.st == tap_pkg::ST_LEAD && !PULSE_OUT && s_r.cnt == $past(s_r.rld))
    else $error("8-bit pwm lead phase not low");
  chk_reset_start: assert property (@(posedge MCLK) // RL10
    !$past(RST_N) |-> !s_r.start) else $error("start set after reset");
  chk_written_read: assert property (@(posedge MCLK) disable iff (!RST_N) // RL13
    (wr_go && wsel[1] && s_r.wstrb == 4'hF && s_r.st == tap_pkg::ST_IDLE)
    |=> s_r.cnt == $past(s_r.wdata[15:0])) else $error("stopped write not in counter");
  chk_oneshot_stop: assert property (@(posedge MCLK) disable iff (!RST_N) // RL16
    (s_r.mode == tap_pkg::MD_ONESHOT && !s_r.start && s_r.st == tap_pkg::ST_HIGH)
    |=> s_r.cnt == $past(s_r.rld) && !PULSE_OUT && IRQ_FLAG) else $error("one-shot stop wrong");
  chk_mode_entry_flag: assert property (@(posedge MCLK) disable iff (!RST_N) // RL24
    (wr_go && wsel[0] && s_r.wstrb[0] && !s_r.mode[1] && s_r.wdata[2]) |=> IRQ_FLAG)
    else $error("mode entry did not set flag");
  chk_reload_read: assert property (@(posedge MCLK) disable iff (!RST_N) // RL12
    (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[7:0] == `TAP_OFF_TIMER && s_r.rl_inst && !s_r.up)
    |=> S_AXI_RDATA == 32'h0000FFFF) else $error("reload instant read not all ones");

endmodule : tap_timer_chan

// ---- testbench/tap_pin_model.sv ----
// pin-side partner: drives the trigger pin and times the pulse output levels
`timescale 1ns/100ps
module tap_pin_model (
  input wire logic MCLK,
  input wire logic PULSE_OUT,
  output logic TRIG_IN
);
  int run_len = 0;
  int hi_w = 0;
  int lo_w = 0;
  logic last = 1'b0;
  initial TRIG_IN = 1'b0;
  // ----------------
  // trigger edges
  // ----------------
  // eight clocks apart keeps edges more than one tick away only with the undivided main-clock source
  task automatic drive(input logic lvl);
    repeat (8) @(posedge MCLK);
    TRIG_IN <= lvl;
  endtask : drive
  // ----------------
  // level timing, in clocks
  // ----------------
  always @(posedge MCLK) begin
    if (PULSE_OUT !== last) begin
      if (last) hi_w <= run_len;
      else lo_w <= run_len;
      run_len <= 1;
      last <= PULSE_OUT;
    end else begin
      run_len <= run_len + 1;
    end
  end
endmodule : tap_pin_model

// ---- testbench/timer_a_pwm_and_oneshot_bench.sv ----
// self-checking bench of the timer channel: bus tasks and mode sequences
`timescale 1ns/100ps
`include "tap_defs.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module timer_a_pwm_and_oneshot_bench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] awaddr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] araddr = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic trig, awready, wready, bvalid, arready, rvalid, pulse, irq, ovf_o;
  logic [1:0] bresp, rresp, rr;
  logic [31:0] rdata, rv, rv0;
  int n_mismatch = 0;
  int checks = 0;
  int k;
  logic [2:0] ovf = 3'h0;
  logic [3:0] sc = 4'h0;
  logic [3:0] be = 4'hF;
  always #50 mclk = ~mclk;
  always @(posedge mclk) sc <= sc + 4'h1;
  tap_timer_chan DUT (.MCLK(mclk), .RST_N(rst_n), .TRIG_IN(trig), .SUB_CLK(sc[3]), .UNIT2_OVF(ovf[0]),
    .LOWER_OVF(ovf[1]), .UPPER_OVF(ovf[2]), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PULSE_OUT(pulse),
    .OVF_OUT(ovf_o), .IRQ_FLAG(irq));
  tap_pin_model u_pin (.MCLK(mclk), .PULSE_OUT(pulse), .TRIG_IN(trig));
  // ----------------
  // bus and helper tasks
  // ----------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic busy;
    busy = 1'b1;
    @(posedge mclk);
    awaddr <= {24'h0, a};
    wdata <= d;
    wstrb <= be;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (busy) begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        busy = 1'b0;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic busy;
    busy = 1'b1;
    @(posedge mclk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (busy) begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rv = rdata;
        rr = rresp;
        rready <= 1'b0;
        busy = 1'b0;
      end
    end
  endtask : rd
  function automatic logic [31:0] ctl(input logic st, input tap_pkg::tap_mode_t md, input logic p8,
    input tap_pkg::tap_trig_t ts, input tap_pkg::tap_clk_t cs);
    return {20'h0, 2'h0, cs, 2'h0, ts, p8, md, st};
  endfunction : ctl
  // k counts the clocks spent waiting for the output level
  task automatic wait_out(input logic lvl, input int lim);
    k = 0;
    while (pulse !== lvl && k < lim) begin
      @(posedge mclk);
      k++;
    end
    `CHK(pulse, lvl)
  endtask : wait_out
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  // ----------------
  // test sequence
  // ----------------
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(`TAP_OFF_CTRL);
    `CHK(rv, 32'h0)
    rd(8'h10);
    `CHK({rr, rv}, {2'h2, 32'h0})
    $display("test reset done");
    wr(`TAP_OFF_CTRL, ctl(1'b0, tap_pkg::MD_PWM, 1'b0, tap_pkg::TS_RISE, tap_pkg::CS_DIV1));
    `CHK(irq, 1'b1)
    wr(`TAP_OFF_STATUS, 32'h1);
    wr(`TAP_OFF_TIMER, 32'h0);
    wr(`TAP_OFF_CTRL, ctl(1'b1, tap_pkg::MD_PWM, 1'b0, tap_pkg::TS_RISE, tap_pkg::CS_DIV1));
    u_pin.drive(1'b1);
    repeat (50) @(posedge mclk);
    `CHK({pulse, irq}, 2'b00)
    wr(`TAP_OFF_CTRL, ctl(1'b0, tap_pkg::MD_PWM, 1'b0, tap_pkg::TS_RISE, tap_pkg::CS_DIV1));
    wr(`TAP_OFF_TIMER, 32'h5);
    rd(`TAP_OFF_TIMER);
    `CHK(rv, 32'h5)
    wr(`TAP_OFF_CTRL, ctl(1'b1, tap_pkg::MD_PWM, 1'b0, tap_pkg::TS_RISE, tap_pkg::CS_DIV1));
    u_pin.drive(1'b0);
    u_pin.drive(1'b1);
    wait_out(1'b1, 40);
    wait_out(1'b0, 40);
    @(posedge mclk);
    `CHK(u_pin.hi_w, 5)
    `CHK(irq, 1'b1)
    wait_out(1'b1, 70000);
    @(posedge mclk);
    `CHK(u_pin.lo_w, 65530)
    wait_out(1'b0, 40);
    @(posedge mclk);
    `CHK(u_pin.hi_w, 5)
    $display("test pwm16 done");
    wr(`TAP_OFF_STATUS, 32'h1);
    wr(`TAP_OFF_CTRL, ctl(1'b0, tap_pkg::MD_PWM, 1'b0, tap_pkg::TS_RISE, tap_pkg::CS_DIV1));
    repeat (2) @(posedge mclk);
    `CHK({pulse, irq}, 2'b00)
    rd(`TAP_OFF_TIMER);
    rv0 = rv;
    repeat (20) @(posedge mclk);
    rd(`TAP_OFF_TIMER);
    `CHK(rv, rv0)
    wr(`TAP_OFF_TIMER, 32'h400);
    wr(`TAP_OFF_CTRL, ctl(1'b1, tap_pkg::MD_PWM, 1'b0, tap_pkg::TS_RISE, tap_pkg::CS_DIV1));
    u_pin.drive(1'b0);
    u_pin.drive(1'b1);
    wait_out(1'b1, 40);
    repeat (20) @(posedge mclk);
    wr(`TAP_OFF_CTRL, ctl(1'b0, tap_pkg::MD_PWM, 1'b0, tap_pkg::TS_RISE, tap_pkg::CS_DIV1));
    repeat (2) @(posedge mclk);
    `CHK({pulse, irq}, 2'b01)
    wr(`TAP_OFF_TIMER, 32'h3);
    wr(`TAP_OFF_CTRL, ctl(1'b1, tap_pkg::MD_PWM, 1'b0, tap_pkg::TS_RISE, tap_pkg::CS_DIV8));
    u_pin.drive(1'b0);
    u_pin.drive(1'b1);
    wait_out(1'b1, 80);
    wait_out(1'b0, 80);
    @(posedge mclk);
    `CHK(u_pin.hi_w, 24)
    $display("test stop and source done");
    wr(`TAP_OFF_CTRL, ctl(1'b0, tap_pkg::MD_PWM, 1'b1, tap_pkg::TS_FALL, tap_pkg::CS_DIV1));
    wr(`TAP_OFF_TIMER, 32'h201);
    wr(`TAP_OFF_CTRL, ctl(1'b1, tap_pkg::MD_PWM, 1'b1, tap_pkg::TS_FALL, tap_pkg::CS_DIV1));
    u_pin.drive(1'b0);
    wait_out(1'b1, 40);
    `CHK(k >= 4 && k <= 12, 1'b1)
    wait_out(1'b0, 40);
    wait_out(1'b1, 600);
    @(posedge mclk);
    `CHK(u_pin.hi_w, 4)
    `CHK(u_pin.lo_w, 506)
    wr(`TAP_OFF_CTRL, ctl(1'b0, tap_pkg::MD_PWM, 1'b1, tap_pkg::TS_FALL, tap_pkg::CS_DIV1));
    wr(`TAP_OFF_TIMER, 32'h33);
    wr(`TAP_OFF_CTRL, ctl(1'b1, tap_pkg::MD_PWM, 1'b1, tap_pkg::TS_FALL, tap_pkg::CS_DIV1));
    u_pin.drive(1'b1);
    u_pin.drive(1'b0);
    repeat (600) @(posedge mclk);
    `CHK(pulse, 1'b0)
    $display("test pwm8 done");
    wr(`TAP_OFF_CTRL, ctl(1'b0, tap_pkg::MD_TIMER, 1'b0, tap_pkg::TS_SOFT, tap_pkg::CS_DIV1));
    wr(`TAP_OFF_STATUS, 32'h1);
    wr(`TAP_OFF_CTRL, ctl(1'b0, tap_pkg::MD_ONESHOT, 1'b0, tap_pkg::TS_SOFT, tap_pkg::CS_DIV1));
    `CHK(irq, 1'b1)
    wr(`TAP_OFF_STATUS, 32'h1);
    wr(`TAP_OFF_TIMER, 32'h64);
    wr(`TAP_OFF_CTRL, ctl(1'b1, tap_pkg::MD_ONESHOT, 1'b0, tap_pkg::TS_SOFT, tap_pkg::CS_DIV1));
    wr(`TAP_OFF_SWTRIG, 32'h1);
    wait_out(1'b1, 20);
    repeat (10) @(posedge mclk);
    wr(`TAP_OFF_CTRL, ctl(1'b0, tap_pkg::MD_ONESHOT, 1'b0, tap_pkg::TS_SOFT, tap_pkg::CS_DIV1));
    repeat (2) @(posedge mclk);
    `CHK({pulse, irq}, 2'b01)
    rd(`TAP_OFF_TIMER);
    `CHK(rv, 32'h64)
    be = 4'h1;
    wr(`TAP_OFF_TIMER, 32'h5502);
    be = 4'hF;
    wr(`TAP_OFF_CTRL, ctl(1'b1, tap_pkg::MD_ONESHOT, 1'b0, tap_pkg::TS_OVF, tap_pkg::CS_SUB32) | 32'h40);
    ovf <= 3'h5;
    rd(`TAP_OFF_STATUS);
    `CHK(rv[2], 1'b0)
    ovf <= 3'h2;
    @(posedge mclk);
    ovf <= 3'h0;
    wait_out(1'b1, 600);
    repeat (520) @(posedge mclk);
    ovf <= 3'h2;
    @(posedge mclk);
    ovf <= 3'h0;
    wait_out(1'b0, 2200);
    @(posedge mclk);
    `CHK(u_pin.hi_w, 2560)
    wr(`TAP_OFF_TIMER, 32'hFFFF);
    wr(`TAP_OFF_CTRL, ctl(1'b1, tap_pkg::MD_EVENT, 1'b0, tap_pkg::TS_OVF, tap_pkg::CS_DIV1) | 32'hC00);
    ovf <= 3'h1;
    @(posedge mclk);
    ovf <= 3'h0;
    rd(`TAP_OFF_TIMER);
    `CHK(rv, 32'h0)
    $display("test oneshot done");
    wr(`TAP_OFF_CTRL, ctl(1'b0, tap_pkg::MD_TIMER, 1'b0, tap_pkg::TS_SOFT, tap_pkg::CS_DIV1));
    wr(`TAP_OFF_TIMER, 32'hFF);
    wr(`TAP_OFF_CTRL, ctl(1'b1, tap_pkg::MD_TIMER, 1'b0, tap_pkg::TS_SOFT, tap_pkg::CS_DIV1));
    rd(`TAP_OFF_TIMER);
    `CHK(rv < 32'hFF, 1'b1)
    wr(`TAP_OFF_TIMER, 32'h0);
    repeat (300) @(posedge mclk);
    rd(`TAP_OFF_TIMER);
    `CHK({ovf_o, rv}, {1'b1, 32'hFFFF})
    $display("test timer read done");
    report_and_stop();
  end
  // hang guard sized above the full 16-bit period plus the shorter tests
  initial begin
    repeat (90000) @(posedge mclk);
    n_mismatch++;
    report_and_stop();
  end
endmodule : timer_a_pwm_and_oneshot_bench
